/* imv_pkg.sv */
// Constants and helpers shared by the interrupt mask and vector block
package imv_pkg;
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MASK_A = 8'he0;
  localparam logic [7:0] IDX_MASK_B = 8'he1;
  localparam logic [7:0] IDX_VECTOR = 8'he2;
  localparam logic [11:0] ADDR_MASK_A = {2'h0, IDX_MASK_A, 2'h0};
  localparam logic [11:0] ADDR_MASK_B = {2'h0, IDX_MASK_B, 2'h0};
  localparam logic [11:0] ADDR_VECTOR = {2'h0, IDX_VECTOR, 2'h0};
  localparam logic [7:0] MASK_A_RESET = 8'h00;
  localparam logic [7:0] MASK_B_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam logic [7:0] MASK_B_WRITABLE = 8'he0;
  // Mask group a field positions
  localparam int unsigned A_POWER_ON_LOW_VOLTAGE_EVENT = 0;
  localparam int unsigned A_EXT_PIN_ZERO = 1;
  localparam int unsigned A_SPI_TX = 2;
  localparam int unsigned A_SPI_RX = 3;
  localparam int unsigned A_GPIO0 = 4;
  localparam int unsigned A_EXT_PIN_ONE = 5;
  localparam int unsigned A_SLEEP = 6;
  localparam int unsigned A_GPIO1 = 7;
  // Mask group b field positions
  localparam int unsigned B_ONE_MS = 5;
  localparam int unsigned B_INTERVAL = 6;
  localparam int unsigned B_CAPTURE = 7;
  // Source index in the flat pending vector; group b follows group a
  localparam int unsigned S_ONE_MS = 8;
  localparam int unsigned S_INTERVAL = 9;
  localparam int unsigned S_CAPTURE = 10;
  localparam logic [7:0] VECTOR_NONE = 8'h00;
  localparam logic [7:0] VECTOR_STEP = 8'h04;

  // Lowest source index has the highest priority
  function automatic logic [7:0] vector_of(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'((8'(idx) + 8'h01) * VECTOR_STEP);
    return v;
  endfunction

  function automatic logic [NUM_SRC-1:0] flat_mask(input logic [7:0] ma, input logic [7:0] mb);
    return {mb[B_CAPTURE], mb[B_INTERVAL], mb[B_ONE_MS], ma};
  endfunction
endpackage

/* imv_posted.sv */
// Posted interrupt flags with mask gating into the pending set
`timescale 1ns/1ps
module imv_posted #(
  parameter int unsigned N = imv_pkg::NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [N-1:0] src_event,
  input wire logic [N-1:0] mask,
  input wire logic clear_pending,
  output logic [N-1:0] posted,
  output logic [N-1:0] pending
);
  logic [N-1:0] posted_r;
  logic [N-1:0] posted_nxt;

  always_comb begin
    posted_nxt = posted_r;
    // Only unmasked flags are dropped; masked ones wait for their mask
    if (clear_pending) begin
      posted_nxt = posted_nxt & ~mask;
    end
    // Set wins over a clear in the same cycle
    posted_nxt = posted_nxt | src_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      posted_r <= '0;
    end else if (clk_en) begin
      posted_r <= posted_nxt;
    end
  end

  assign posted = posted_r;
  assign pending = posted_r & mask;
endmodule // imv_posted

/* imv_prio_enc.sv */
// Picks the highest priority pending source and gives its vector code
`timescale 1ns/1ps
module imv_prio_enc #(
  parameter int unsigned N = imv_pkg::NUM_SRC
) (
  input wire logic [N-1:0] pending,
  output logic [7:0] vector
);
  always_comb begin
    vector = imv_pkg::VECTOR_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        vector = imv_pkg::vector_of(4'(i));
      end
    end
  end
endmodule // imv_prio_enc

/* imv_top.sv */
// Interrupt mask and vector block with an APB register slave
// Contract
// - Mask b bit 7 gates capture channel zero; 0 masks, 1 unmasks.
// - Mask b bit 6 gates the interval timer; 1 unmasks, 0 masks.
// - Mask b bit 5 gates the 1 ms timer; 0 masks, 1 unmasks.
// - Mask a bit 7 gates GPIO port 1; 1 unmasks, 0 masks.
// - Mask a bit 6 gates the sleep timer; 0 masks, 1 unmasks.
// - Mask a bits 5 and 1 gate external pins one and zero.
// - Mask a bit 4 gates GPIO port 0; 0 masks, 1 unmasks.
// - Mask a bits 3 and 2 gate SPI receive and transmit.
// - Mask a bit 0 gates power-on / low-voltage; 0 masks, 1 unmasks.
// - Reading the vector register returns the highest priority pending code.
// - Any write to the vector register clears all pending interrupts except those whose event arrives in the same cycle.
// - Cleared mask keeps a posted interrupt out of the pending set.
// - Sources still post while masked; pending follows once unmasked.
`timescale 1ns/1ps
module imv_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [imv_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_low_voltage_event,
  input wire logic ext_pin_irq_zero,
  input wire logic spi_tx_event,
  input wire logic spi_rx_event,
  input wire logic gpio_port0_event,
  input wire logic ext_pin_irq_one,
  input wire logic sleep_timer_event,
  input wire logic gpio_port1_event,
  input wire logic one_ms_timer_event,
  input wire logic interval_timer_event,
  input wire logic capture_channel_zero_event,
  output logic irq_request
);
  localparam int unsigned N = imv_pkg::NUM_SRC;

  logic [7:0] source_mask_group_a_r;
  logic [7:0] source_mask_group_a_nxt;
  logic [7:0] source_mask_group_b_r;
  logic [7:0] source_mask_group_b_nxt;
  logic [7:0] pending_vector_clear_r;
  logic [7:0] pending_vector_clear_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_request_r;
  logic irq_request_nxt;

  logic [N-1:0] src_event;
  logic [N-1:0] mask_flat;
  logic [N-1:0] posted;
  logic [N-1:0] pending;
  logic [7:0] vector_now;
  logic access;
  logic wr_done;
  logic hit_a;
  logic hit_b;
  logic hit_v;
  logic clear_pending;

  assign src_event = {capture_channel_zero_event, interval_timer_event, one_ms_timer_event,
                      gpio_port1_event, sleep_timer_event, ext_pin_irq_one, gpio_port0_event,
                      spi_rx_event, spi_tx_event, ext_pin_irq_zero,
                      power_on_low_voltage_event};
  assign mask_flat = imv_pkg::flat_mask(source_mask_group_a_r, source_mask_group_b_r);

  // Access phase holds one wait state so read data comes from a flop
  assign access = psel && penable;
  assign wr_done = access && pready_r && pwrite;
  assign hit_a = (paddr == imv_pkg::ADDR_MASK_A);
  assign hit_b = (paddr == imv_pkg::ADDR_MASK_B);
  assign hit_v = (paddr == imv_pkg::ADDR_VECTOR);
  assign clear_pending = wr_done && hit_v;

  imv_posted #(
    .N(N)
  ) u_posted (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .src_event(src_event),
    .mask(mask_flat),
    .clear_pending(clear_pending),
    .posted(posted),
    .pending(pending)
  );

  imv_prio_enc #(
    .N(N)
  ) u_prio_enc (
    .pending(pending),
    .vector(vector_now)
  );

  // Register file and APB answer
  always_comb begin
    source_mask_group_a_nxt = source_mask_group_a_r;
    source_mask_group_b_nxt = source_mask_group_b_r;
    pending_vector_clear_nxt = vector_now;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = access && !pready_r;
    irq_request_nxt = |pending;
    if (access && !pready_r) begin
      pslverr_nxt = !(hit_a || hit_b || hit_v);
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit_a: prdata_nxt = {24'h00_0000, source_mask_group_a_r};
          hit_b: prdata_nxt = {24'h00_0000, source_mask_group_b_r};
          hit_v: prdata_nxt = {24'h00_0000, pending_vector_clear_r};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (wr_done && hit_a) begin
      source_mask_group_a_nxt = pwdata[7:0];
    end
    if (wr_done && hit_b) begin
      // Reserved low bits never take a one
      source_mask_group_b_nxt = pwdata[7:0] & imv_pkg::MASK_B_WRITABLE;
    end
    if (clear_pending) begin
      // Shows the cleared state on the next read without a stale code
      pending_vector_clear_nxt = imv_pkg::VECTOR_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_mask_group_a_r <= imv_pkg::MASK_A_RESET;
      source_mask_group_b_r <= imv_pkg::MASK_B_RESET;
      pending_vector_clear_r <= imv_pkg::VECTOR_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_request_r <= 1'b0;
    end else if (clk_en) begin
      source_mask_group_a_r <= source_mask_group_a_nxt;
      source_mask_group_b_r <= source_mask_group_b_nxt;
      pending_vector_clear_r <= pending_vector_clear_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_request_r <= irq_request_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_request = irq_request_r;

  // Checks
  // Mask gating per source
  a_capture_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pending[imv_pkg::S_CAPTURE] == (posted[imv_pkg::S_CAPTURE]
      && source_mask_group_b_r[imv_pkg::B_CAPTURE])))
    else $error("capture pending disagrees with mask");

  a_interval_gate: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && interval_timer_event && source_mask_group_b_r[imv_pkg::B_INTERVAL]
      && !(wr_done && hit_b) |=> pending[imv_pkg::S_INTERVAL])
    else $error("unmasked interval event not pending");

  a_one_ms_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !source_mask_group_b_r[imv_pkg::B_ONE_MS] |-> !pending[imv_pkg::S_ONE_MS])
    else $error("masked 1 ms source pending");

  a_gpio1_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !source_mask_group_a_r[imv_pkg::A_GPIO1] |-> !pending[imv_pkg::A_GPIO1])
    else $error("masked port 1 source pending");

  a_sleep_gate: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sleep_timer_event && source_mask_group_a_r[imv_pkg::A_SLEEP]
      && !(wr_done && hit_a) |=> pending[imv_pkg::A_SLEEP])
    else $error("unmasked sleep event not pending");

  a_ext_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pending[imv_pkg::A_EXT_PIN_ONE] |-> source_mask_group_a_r[imv_pkg::A_EXT_PIN_ONE])
      and (pending[imv_pkg::A_EXT_PIN_ZERO] |-> source_mask_group_a_r[imv_pkg::A_EXT_PIN_ZERO]))
    else $error("masked external pin pending");

  a_gpio0_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !source_mask_group_a_r[imv_pkg::A_GPIO0] |-> !pending[imv_pkg::A_GPIO0])
    else $error("masked port 0 source pending");

  a_spi_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pending[imv_pkg::A_SPI_RX] |-> source_mask_group_a_r[imv_pkg::A_SPI_RX])
      and (pending[imv_pkg::A_SPI_TX] |-> source_mask_group_a_r[imv_pkg::A_SPI_TX]))
    else $error("masked SPI source pending");

  a_por_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !source_mask_group_a_r[imv_pkg::A_POWER_ON_LOW_VOLTAGE_EVENT] |-> !pending[imv_pkg::A_POWER_ON_LOW_VOLTAGE_EVENT])
    else $error("masked power source pending");

  a_all_masked: assert property (@(posedge pclk) disable iff (!presetn)
    source_mask_group_a_r == 8'h00 && source_mask_group_b_r == 8'h00 |-> pending == '0)
    else $error("pending set while every source masked");

  // Register writes and holds
  a_mask_a_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_done && hit_a |=> source_mask_group_a_r == $past(pwdata[7:0]))
    else $error("mask a write did not land");

  a_mask_b_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_done && hit_b
      |=> source_mask_group_b_r == ($past(pwdata[7:0]) & imv_pkg::MASK_B_WRITABLE))
    else $error("mask b write did not land");

  a_mask_a_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(clk_en && wr_done && hit_a) |=> $stable(source_mask_group_a_r))
    else $error("mask a changed without a write");

  a_mask_b_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(clk_en && wr_done && hit_b) |=> $stable(source_mask_group_b_r))
    else $error("mask b changed without a write");

  a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(posted) && $stable(pending_vector_clear_r) && $stable(pready_r)
      && $stable(prdata_r) && $stable(irq_request_r))
    else $error("state moved while clock enable low");

  // Posting, clearing and the vector code
  a_post_events: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !clear_pending |=> posted == ($past(posted) | $past(src_event)))
    else $error("posted flags not the sum of events");

  a_clear_spares: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && clear_pending |=> ($past(posted) & ~$past(mask_flat) & ~posted) == '0)
    else $error("clear dropped a masked posted flag");

  // An event racing the clear must not be lost, or the source would go silent
  a_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && clear_pending && src_event != '0
      |=> (posted & $past(src_event)) == $past(src_event))
    else $error("event lost to a clear in the same cycle");

  a_vector_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !clear_pending |=> pending_vector_clear_r == $past(vector_now))
    else $error("vector register lags the encoder");

  a_vector_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (pending == '0) == (vector_now == imv_pkg::VECTOR_NONE))
    else $error("vector code disagrees with pending set");

  a_vector_top: assert property (@(posedge pclk) disable iff (!presetn)
    pending[imv_pkg::A_POWER_ON_LOW_VOLTAGE_EVENT] |-> vector_now == imv_pkg::VECTOR_STEP)
    else $error("highest priority source not chosen");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> irq_request_r == ($past(pending) != '0))
    else $error("request line does not follow pending");

  // Register bus answer
  a_vector_read: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && access && !pready_r && !pwrite && hit_v
      |=> pready_r && prdata_r == {24'h00_0000, $past(pending_vector_clear_r)})
    else $error("vector read data wrong");

  a_vector_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && clear_pending && src_event == '0 |=> (pending == '0)
      && pending_vector_clear_r == imv_pkg::VECTOR_NONE)
    else $error("vector write left pending work");

  a_masked_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && capture_channel_zero_event && !source_mask_group_b_r[imv_pkg::B_CAPTURE]
      |=> posted[imv_pkg::S_CAPTURE])
    else $error("masked source did not post");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (source_mask_group_b_r & ~imv_pkg::MASK_B_WRITABLE) == 8'h00)
    else $error("reserved mask bits set");

  a_read_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && access && !pready_r && !pwrite && hit_b |=> prdata_r[4:0] == 5'h00)
    else $error("reserved mask b bits read as one");

  a_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && access && !pready_r |=> pready_r)
    else $error("access not answered after one wait state");

  a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && access && !pready_r && !(hit_a || hit_b || hit_v)
      |=> pslverr_r && prdata_r == '0)
    else $error("unmapped access not flagged");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_r && clk_en |=> !pready_r)
    else $error("pready held over two cycles");

  a_reset_clean: assert property (@(posedge pclk)
    $rose(presetn) |-> source_mask_group_a_r == 8'h00 && source_mask_group_b_r == 8'h00
      && pending_vector_clear_r == 8'h00)
    else $error("registers not cleared by reset");
endmodule // imv_top

/* imv_src_model.sv */
// Event generator standing in for the on-chip interrupt sources
`timescale 1ns/1ps
module imv_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [10:0] trig,
  input wire logic slow,
  output logic [10:0] ev
);
  logic [10:0] dly_r;
  // Slow sources fire one cycle later, like a peripheral behind its own pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_r <= 11'h000;
      ev <= 11'h000;
    end else begin
      dly_r <= slow ? trig : 11'h000;
      ev <= (slow ? 11'h000 : trig) | dly_r;
    end
  end
endmodule // imv_src_model

/* interrupt_mask_and_vector_tb.sv */
// Self-checking testbench for the interrupt mask and vector block
`timescale 1ns/1ps
module interrupt_mask_and_vector_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request, slow, e, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [10:0] trig, ev, s, m;
  int errors, checks_done;
  integer seed;

  imv_src_model imv_src_model_i (.pclk(pclk), .presetn(presetn), .trig(trig), .slow(slow),
    .ev(ev));
  imv_top imv_top_i (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_on_low_voltage_event(ev[0]),
    .ext_pin_irq_zero(ev[1]), .spi_tx_event(ev[2]), .spi_rx_event(ev[3]),
    .gpio_port0_event(ev[4]), .ext_pin_irq_one(ev[5]), .sleep_timer_event(ev[6]),
    .gpio_port1_event(ev[7]), .one_ms_timer_event(ev[8]), .interval_timer_event(ev[9]),
    .capture_channel_zero_event(ev[10]), .irq_request(irq_request));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task summarize;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Lowest flat index wins; code is (index+1)*4, zero when idle
  function automatic logic [31:0] exp_vec(input logic [10:0] p);
    for (int k = 0; k < 11; k++) if (p[k]) return 32'((k + 1) * 4);
    return 32'h00000000;
  endfunction

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task setm(input logic [10:0] mm);
    apb(1'b1, imv_pkg::ADDR_MASK_A, {24'h000000, mm[7:0]});
    apb(1'b1, imv_pkg::ADDR_MASK_B, {24'h000000, mm[10:8], 5'h1f});
  endtask

  // Fixed wait covers event register plus post and vector stages
  task fire(input logic [10:0] ss, input logic sl);
    trig <= ss;
    slow <= sl;
    @(posedge pclk);
    trig <= 11'h000;
    repeat (5) @(posedge pclk);
  endtask

  task rdvec(input logic [31:0] x);
    apb(1'b0, imv_pkg::ADDR_VECTOR, 32'h00000000);
    chk(r, x);
  endtask

  initial begin
    seed = 32'h52204540;
    errors = 0;
    checks_done = 0;
    {psel, penable, pwrite, slow, presetn} = 5'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    trig = 11'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, imv_pkg::ADDR_MASK_A, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, imv_pkg::ADDR_MASK_B, 32'h0);
    chk(r, 32'h0);
    rdvec(32'h0);
    apb(1'b1, imv_pkg::ADDR_MASK_B, 32'hffffffff);
    apb(1'b0, imv_pkg::ADDR_MASK_B, 32'h0);
    chk(r, 32'he0);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      setm(11'h000);
      fire(11'(1 << i), 1'(i));
      rdvec(32'h0);
      chk({31'h0, irq_request}, 32'h0);
      setm(11'(1 << i));
      rdvec(exp_vec(11'(1 << i)));
      chk({31'h0, irq_request}, 32'h1);
      apb(1'b1, imv_pkg::ADDR_VECTOR, $random(seed));
      rdvec(32'h0);
    end
    $display("test single sources done");
    // Events while the clock enable is low must leave no trace
    setm(11'h7ff);
    ce <= 1'b0;
    fire(11'h7ff, 1'b0);
    ce <= 1'b1;
    rdvec(32'h0);
    fire(11'h401, 1'b1);
    rdvec(32'h04);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, imv_pkg::ADDR_MASK_A, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, imv_pkg::ADDR_MASK_B, 32'h0);
    chk(r, 32'h0);
    rdvec(32'h0);
    setm(11'h7ff);
    rdvec(32'h0);
    $display("test enable and reset done");
    repeat (20) begin
      s = 11'($random(seed));
      m = 11'($random(seed));
      setm(m);
      fire(s, s[0]);
      apb(1'b0, imv_pkg::ADDR_MASK_A, 32'h0);
      chk(r, {24'h0, m[7:0]});
      rdvec(exp_vec(s & m));
      apb(1'b1, imv_pkg::ADDR_VECTOR, $random(seed));
      rdvec(32'h0);
      setm(11'h7ff);
      rdvec(exp_vec(s & ~m));
      apb(1'b1, imv_pkg::ADDR_VECTOR, 32'h0);
      rdvec(32'h0);
    end
    $display("test random priority done");
    summarize();
  end
endmodule // interrupt_mask_and_vector_tb
